/* inc/ast_params.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH

// Register byte offsets on the APB
`define AST_OFF_TSC 8'h00
`define AST_OFF_RSC 8'h04
`define AST_OFF_HOLD 8'h08
`define AST_OFF_BAUD 8'h0c
`define AST_OFF_PFLAG 8'h10
`define AST_OFF_PIE 8'h14
`define AST_OFF_INTC 8'h18
`define AST_OFF_PIN 8'h1c

// Field positions
`define AST_TSC_NINE_EN 6
`define AST_TSC_TE 5
`define AST_TSC_SYNC 4
`define AST_TSC_SHIFT_EMPTY 1
`define AST_TSC_NINTH 0
`define AST_RSC_PORT_EN 7
`define AST_RSC_RX_EN 4
`define AST_PF_TXF 4
`define AST_PIE_TXE 4
`define AST_INTC_GLOBAL 7
`define AST_INTC_PERIPH 6
`define AST_BAUD_WIDE 16

// Reset values
`define AST_BAUD_RST 16'h0000
`define AST_PIN_RST 4'h3

// Timing: clock rate, instruction cycle and baud prescale
`define AST_CLK_MHZ 25
`define AST_INSTR_NS 160
`define AST_INSTR_CYC ((`AST_INSTR_NS * `AST_CLK_MHZ + 999) / 1000)
`define AST_FLAG_CYC (2 * `AST_INSTR_CYC)
`define AST_BAUD_PRESCALE 16

`endif

/* inc/ast_pkg.sv */
// Types shared by the serial transmitter files
package ast_pkg;

  // Transmitter frame state
  typedef enum logic [1:0] {
    ast_idle,
    ast_send,
    ast_gap
  } ast_state_e;

  // Writable transmit status and control fields
  typedef struct packed {
    logic nine_en;
    logic te;
    logic sync_mode;
    logic ninth;
  } ast_tsc_s;

  // Interrupt enables and gates
  typedef struct packed {
    logic ie;
    logic peripheral_irq_gate;
    logic global_irq_enable;
  } ast_irq_s;

endpackage : ast_pkg

/* hdl/ast_baud.sv */
// Baud generator: one tick per bit period while a frame runs
`timescale 1ns/1ps
`include "ast_params.svh"
module ast_baud (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic wide,
  input wire logic [15:0] divisor,
  output logic tick
);

  localparam logic [3:0] PRE_LAST = 4'(`AST_BAUD_PRESCALE - 1);

  logic [3:0] pre;
  logic [15:0] cnt;
  logic [15:0] div_eff;

  // Narrow mode uses only the low byte of the divisor
  function automatic logic [15:0] eff_div(input logic w, input logic [15:0] d);
    eff_div = w ? d : {8'h00, d[7:0]};
  endfunction : eff_div

  assign div_eff = eff_div(wide, divisor);

  // Terminal count is decoded directly so every bit lasts the same
  assign tick = run && (pre == PRE_LAST) && (cnt == div_eff);

  // Counters restart with each frame, so the start bit is a full period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre <= 4'h0;
      cnt <= 16'h0000;
    end else if (!run || tick) begin
      pre <= 4'h0;
      cnt <= 16'h0000;
    end else if (pre == PRE_LAST) begin
      pre <= 4'h0;
      cnt <= cnt + 16'h0001;
    end else begin
      pre <= pre + 4'h1;
    end
  end

endmodule : ast_baud

/* hdl/ast_tx.sv */
// Asynchronous serial transmitter with APB register access
`timescale 1ns/1ps
`include "ast_params.svh"
module ast_tx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_out_pin_in,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe,
  input wire logic serial_in_pin_in,
  output logic serial_in_pin_out,
  output logic serial_in_pin_oe,
  output logic irq
);

  localparam int INSTR_C = `AST_INSTR_CYC;
  localparam logic [7:0] GAP_LAST = 8'(`AST_INSTR_CYC - 1);
  localparam logic [7:0] FLAG_LOAD = 8'(`AST_FLAG_CYC);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  ast_pkg::ast_tsc_s tsc;
  ast_pkg::ast_irq_s irqc;
  ast_pkg::ast_state_e state;
  logic serial_port_enable;
  logic continuous_receive_enable;
  logic [15:0] baud_div;
  logic baud_wide;
  logic [3:0] pin_ctl;
  logic [7:0] hold;
  logic hold9;
  logic hold_full;
  logic [9:0] shreg;
  logic [3:0] left;
  logic tx_bit;
  logic [7:0] gap_cnt;
  logic [7:0] flag_dly;
  logic buffer_empty_flag;
  logic tick;
  logic run;
  logic load;
  logic done;
  logic shift_register_empty_flag;
  logic tx_forced;
  logic rx_forced;
  logic access;
  logic wr;
  logic wr_hold;
  logic [1:0] in_meta;
  logic [1:0] in_sync;

  // Address decode, used only by the error answer; the read mux decodes paddr itself
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `AST_OFF_TSC, `AST_OFF_RSC, `AST_OFF_HOLD, `AST_OFF_BAUD,
      `AST_OFF_PFLAG, `AST_OFF_PIE, `AST_OFF_INTC, `AST_OFF_PIN: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access phase after each setup

  assign access = psel && penable && pready;
  assign wr = access && pwrite && !pslverr;
  assign wr_hold = wr && (paddr == `AST_OFF_HOLD);

  // Answer is prepared in the setup cycle so all outputs come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !is_mapped(paddr);
    end
  end

  // Read data mux, captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        `AST_OFF_TSC: begin
          prdata[`AST_TSC_NINE_EN] <= tsc.nine_en;
          prdata[`AST_TSC_TE] <= tsc.te;
          prdata[`AST_TSC_SYNC] <= tsc.sync_mode;
          prdata[`AST_TSC_SHIFT_EMPTY] <= shift_register_empty_flag;
          prdata[`AST_TSC_NINTH] <= tsc.ninth;
        end
        `AST_OFF_RSC: begin
          prdata[`AST_RSC_PORT_EN] <= serial_port_enable;
          prdata[`AST_RSC_RX_EN] <= continuous_receive_enable;
        end
        `AST_OFF_HOLD: prdata[7:0] <= hold;
        `AST_OFF_BAUD: begin
          prdata[15:0] <= baud_div;
          prdata[`AST_BAUD_WIDE] <= baud_wide;
        end
        // flag is visible here but never written
        `AST_OFF_PFLAG: prdata[`AST_PF_TXF] <= buffer_empty_flag;
        `AST_OFF_PIE: prdata[`AST_PIE_TXE] <= irqc.ie;
        `AST_OFF_INTC: begin
          prdata[`AST_INTC_GLOBAL] <= irqc.global_irq_enable;
          prdata[`AST_INTC_PERIPH] <= irqc.peripheral_irq_gate;
        end
        `AST_OFF_PIN: prdata[5:0] <= {in_sync, pin_ctl};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  // Software-written configuration; flags are read-only and not stored here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsc <= '0;
      serial_port_enable <= 1'b0;
      continuous_receive_enable <= 1'b0;
      baud_div <= `AST_BAUD_RST;
      baud_wide <= 1'b0;
      irqc <= '0;
      pin_ctl <= `AST_PIN_RST;
    end else if (wr) begin
      case (paddr)
        `AST_OFF_TSC: begin
          tsc.nine_en <= pwdata[`AST_TSC_NINE_EN];
          tsc.te <= pwdata[`AST_TSC_TE];
          tsc.sync_mode <= pwdata[`AST_TSC_SYNC];
          tsc.ninth <= pwdata[`AST_TSC_NINTH];
        end
        `AST_OFF_RSC: begin
          serial_port_enable <= pwdata[`AST_RSC_PORT_EN];
          continuous_receive_enable <= pwdata[`AST_RSC_RX_EN];
        end
        `AST_OFF_BAUD: begin
          baud_div <= pwdata[15:0];
          baud_wide <= pwdata[`AST_BAUD_WIDE];
        end
        `AST_OFF_PIE: irqc.ie <= pwdata[`AST_PIE_TXE];
        `AST_OFF_INTC: begin
          irqc.global_irq_enable <= pwdata[`AST_INTC_GLOBAL];
          irqc.peripheral_irq_gate <= pwdata[`AST_INTC_PERIPH];
        end
        `AST_OFF_PIN: pin_ctl <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Holding buffer

  assign run = serial_port_enable && tsc.te && !tsc.sync_mode;
  assign done = (state == ast_pkg::ast_send) && tick && (left == 4'h0);
  // idle shifter takes the character at once; in the gap it waits for gap_cnt to reach zero
  assign load = run && hold_full &&
    ((state == ast_pkg::ast_idle) || ((state == ast_pkg::ast_gap) && (gap_cnt == 8'h00)));
  assign shift_register_empty_flag = (state != ast_pkg::ast_send);

  // ninth bit is taken from its field at the moment of the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold <= 8'h00;
      hold9 <= 1'b0;
      hold_full <= 1'b0;
    end else if (!serial_port_enable) begin
      // buffer emptied when the port is switched off
      hold_full <= 1'b0;
    end else if (wr_hold) begin
      hold <= pwdata[7:0];
      hold9 <= tsc.ninth;
      hold_full <= 1'b1;
    end else if (load) begin
      hold_full <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Buffer-empty flag and interrupt

  // write holds the flag up for two instruction cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_dly <= 8'h00;
    end else if (wr_hold && serial_port_enable) begin
      flag_dly <= FLAG_LOAD;
    end else if (flag_dly != 8'h00) begin
      flag_dly <= flag_dly - 8'h01;
    end
  end

  // flag follows buffer state, gated only by the transmit enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_empty_flag <= 1'b0;
    end else begin
      buffer_empty_flag <= tsc.te && (!hold_full || (flag_dly != 8'h00));
    end
  end

  // interrupt when flag and all three enables are set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= buffer_empty_flag && irqc.ie && irqc.peripheral_irq_gate &&
        irqc.global_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Baud generator, restarted per frame

  // one tick per bit period, only while a frame is being sent
  ast_baud u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .run(state == ast_pkg::ast_send),
    .wide(baud_wide),
    .divisor(baud_div),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer and shift register

  // send at once, reload one instruction cycle after the stop bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ast_pkg::ast_idle;
      gap_cnt <= 8'h00;
    end else if (!run) begin
      // abandon the frame; also stops when transmit is disabled
      state <= ast_pkg::ast_idle;
      gap_cnt <= 8'h00;
    end else begin
      case (state)
        ast_pkg::ast_idle: begin
          if (load) begin
            state <= ast_pkg::ast_send;
          end
        end
        ast_pkg::ast_send: begin
          if (done) begin
            state <= ast_pkg::ast_gap;
            gap_cnt <= GAP_LAST;
          end
        end
        ast_pkg::ast_gap: begin
          if (gap_cnt != 8'h00) begin
            gap_cnt <= gap_cnt - 8'h01;
          end else if (load) begin
            state <= ast_pkg::ast_send;
          end else begin
            state <= ast_pkg::ast_idle;
          end
        end
        default: state <= ast_pkg::ast_idle;
      endcase
    end
  end

  // Shift register; stop and idle bits are fed in as ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg <= 10'h3ff;
      left <= 4'h0;
      tx_bit <= 1'b1;
    end else if (!run) begin
      tx_bit <= 1'b1;
      left <= 4'h0;
    end else if (load) begin
      // ninth slot is plain data or stop, never parity
      shreg <= {1'b1, tsc.nine_en ? hold9 : 1'b1, hold};
      left <= tsc.nine_en ? 4'd10 : 4'd9;
      tx_bit <= 1'b0;
    end else if ((state == ast_pkg::ast_send) && tick) begin
      if (left == 4'h0) begin
        tx_bit <= 1'b1;
      end else begin
        // least significant bit goes out first
        tx_bit <= shreg[0];
        shreg <= {1'b1, shreg[9:1]};
        left <= left - 4'h1;
      end
    end else if (state != ast_pkg::ast_send) begin
      tx_bit <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin control and input synchronisers

  assign tx_forced = serial_port_enable && tsc.te && !tsc.sync_mode;
  assign rx_forced = serial_port_enable && continuous_receive_enable && !tsc.sync_mode;

  // transmit pin forced to drive the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_pin_out <= 1'b1;
      serial_out_pin_oe <= 1'b0;
    end else begin
      serial_out_pin_out <= tx_forced ? tx_bit : pin_ctl[2];
      serial_out_pin_oe <= tx_forced || !pin_ctl[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_in_pin_out <= 1'b1;
      serial_in_pin_oe <= 1'b0;
    end else begin
      serial_in_pin_out <= pin_ctl[3];
      serial_in_pin_oe <= !rx_forced && !pin_ctl[1];
    end
  end

  // Pin levels cross in through two flops before software sees them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_meta <= 2'b11;
      in_sync <= 2'b11;
    end else begin
      in_meta <= {serial_in_pin_in, serial_out_pin_in};
      in_sync <= in_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  idle_line_mark_a: assert property (
    (state == ast_pkg::ast_idle) |-> tx_bit)
    else $error("line not at mark while idle");

  start_bit_a: assert property (
    load |=> (!tx_bit && (state == ast_pkg::ast_send)))
    else $error("start bit not space after load");

  stop_bit_a: assert property (
    ((state == ast_pkg::ast_send) && tick && (left == 4'h1)) |=> tx_bit)
    else $error("stop bit not mark");

  bit_steady_a: assert property (
    ((state == ast_pkg::ast_send) && !tick && run) |=> $stable(tx_bit))
    else $error("line moved inside a bit period");

  lsb_first_a: assert property (
    ((state == ast_pkg::ast_send) && tick && (left != 4'h0) && run)
      |=> (tx_bit == $past(shreg[0])))
    else $error("bit order not lsb first");

  gap_reload_a: assert property (
    (done && hold_full && run) |-> ##INSTR_C (load || !run))
    else $error("queued character not loaded after gap");

  flag_hold_a: assert property (
    (wr_hold && tsc.te && serial_port_enable && (!hold_full || (flag_dly != 8'h00)))
      |=> buffer_empty_flag [*2])
    else $error("flag cleared too early after write");

  flag_clear_a: assert property (
    (hold_full && (flag_dly == 8'h00) && $stable(tsc.te)) |=> !buffer_empty_flag)
    else $error("flag set while buffer full");

  irq_gate_a: assert property (
    (buffer_empty_flag && irqc.ie && irqc.peripheral_irq_gate && irqc.global_irq_enable)
      |=> irq)
    else $error("interrupt not raised");

  shifter_busy_a: assert property (
    load |=> !shift_register_empty_flag)
    else $error("shifter empty after load");

  port_abort_a: assert property (
    !serial_port_enable |=> (tx_bit && (state == ast_pkg::ast_idle) && !hold_full))
    else $error("frame not abandoned on port disable");

  force_out_a: assert property (
    tx_forced |=> serial_out_pin_oe)
    else $error("transmit pin not driving");

  force_in_a: assert property (
    rx_forced |=> !serial_in_pin_oe)
    else $error("receive pin still driven");

endmodule : ast_tx

/* testbench/ast_rx_model.sv */
// Remote asynchronous receiver that decodes frames on the serial line
`timescale 1ns/1ps
module ast_rx_model (
  input wire logic pclk,
  input wire logic line,
  input wire logic [15:0] period,
  input wire logic nine,
  output logic got,
  output logic [8:0] data,
  output logic ferr
);
  int p;
  int n;
  int i;
  logic a;
  logic b;
  logic [8:0] d;
  logic err;
  ////////////////////////////////////////////////////////////////////////////////
  // Sample each bit at a quarter and three quarters; drift of one cycle per bit shows up
  initial begin
    got = 1'b0;
    data = 9'h000;
    ferr = 1'b0;
    forever begin
      @(posedge pclk);
      got <= 1'b0;
      if (line === 1'b0) begin
        p = period;
        n = nine ? 9 : 8;
        d = 9'h000;
        err = 1'b0;
        repeat (p / 4 - 1) @(posedge pclk);
        a = line;
        for (i = 0; i <= n + 1; i++) begin
          repeat (p / 2) @(posedge pclk);
          b = line;
          if (a !== b) err = 1'b1;
          if ((i == 0 && a !== 1'b0) || (i == n + 1 && a !== 1'b1)) err = 1'b1;
          // first data bit is bit zero
          if (i >= 1 && i <= n) d[i-1] = a;
          if (i <= n) begin
            repeat (p / 2) @(posedge pclk);
            a = line;
          end
        end
        got <= 1'b1;
        data <= d;
        ferr <= err;
      end
    end
  end
endmodule : ast_rx_model

/* testbench/test_ast_tx.sv */
// Self-checking bench for the serial transmitter over APB
`timescale 1ns/1ps
`include "ast_params.svh"
module test_ast_tx;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic so_out;
  logic so_oe;
  logic si_out;
  logic si_oe;
  logic irq;
  logic si_in;
  logic got;
  logic [8:0] rx_data;
  logic ferr;
  logic ign;
  logic nine_m;
  logic er;
  logic [31:0] rd;
  logic [8:0] c;
  logic [8:0] exp_q[$];
  logic [31:0] bt[4] = '{32'h0001_0002, 32'h0000_0102, 32'h0001_0000, 32'h0000_0101};
  int pt[4] = '{48, 48, 16, 32};
  int err_total;
  int n_compared;
  int cyc;
  int per;
  int hi_cnt;
  int rx_n;
  int n;
  int i;
  integer seed = 32'h3d35;
  wire so_pad;
  // Undriven transmit pad assumed pulled up to mark
  assign so_pad = so_oe ? so_out : 1'b1;

  ast_tx i_ast_tx (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_out_pin_in(so_pad), .serial_out_pin_out(so_out),
    .serial_out_pin_oe(so_oe), .serial_in_pin_in(si_in), .serial_in_pin_out(si_out),
    .serial_in_pin_oe(si_oe), .irq(irq));
  ast_rx_model i_ast_rx_model (.pclk(pclk), .line(so_pad), .period(per[15:0]),
    .nine(nine_m), .got(got), .data(rx_data), .ferr(ferr));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and cycle ceiling
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      $display("ERROR %0t got %h expected %h", $time, g, e);
      err_total++;
    end
  endtask : chk

  // APB master: hold the request until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the cycle ceiling ends a stalled access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk

  task send(input logic [8:0] ch);
    exp_q.push_back(ch);
    apb(1'b1, `AST_OFF_HOLD, {24'h0, ch[7:0]});
  endtask : send

  task wait_rx(input int k);
    while (rx_n < k) begin
      @(posedge pclk);
    end
    repeat (per) @(posedge pclk);
  endtask : wait_rx

  task finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  // Reference receiver results against the queue of written characters
  always @(posedge pclk) begin
    if (got === 1'b1 && !ign) begin
      rx_n++;
      chk({22'h0, ferr, rx_data}, {23'h0, exp_q.pop_front()});
    end
  end
  // Idle run between frames must cover the stop bit plus the load delay
  always @(posedge pclk) begin
    if (so_pad === 1'b1) begin
      hi_cnt++;
    end else begin
      if (hi_cnt > per && hi_cnt < 2 * per && !ign) chk({31'h0, hi_cnt >= per + 4}, 32'h1);
      hi_cnt = 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    si_in = 1'b1;
    ign = 1'b0;
    nine_m = 1'b0;
    per = 32;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk({31'h0, so_pad}, 32'h1);
    chk({31'h0, so_oe}, 32'h0);
    rchk(`AST_OFF_TSC, 32'h2);
    apb(1'b0, `AST_OFF_PIN, 32'h0);
    chk(rd & 32'hf, 32'h3);
    rchk(`AST_OFF_PFLAG, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("test reset done");
    apb(1'b1, `AST_OFF_BAUD, 32'h1);
    apb(1'b1, `AST_OFF_RSC, 32'h90);
    apb(1'b1, `AST_OFF_TSC, 32'h20);
    apb(1'b1, `AST_OFF_PIE, 32'h10);
    apb(1'b1, `AST_OFF_INTC, 32'hc0);
    repeat (2) @(posedge pclk);
    chk({31'h0, so_oe}, 32'h1);
    chk({31'h0, si_oe}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `AST_OFF_PFLAG, 32'h0);
    rchk(`AST_OFF_PFLAG, 32'h10);
    apb(1'b1, `AST_OFF_INTC, 32'h40);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `AST_OFF_INTC, 32'hc0);
    $display("test setup done");
    // Back to back characters; top bit of the first kept low for the idle-run check
    send({1'b0, 1'b0, 7'($random(seed))});
    n = 0;
    while (so_pad !== 1'b0 && n < 100) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(n, 32'd2);
    rchk(`AST_OFF_TSC, 32'h20);
    send({1'b0, 8'($random(seed))});
    rchk(`AST_OFF_PFLAG, 32'h10);
    repeat (8) @(posedge pclk);
    rchk(`AST_OFF_PFLAG, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wait_rx(2);
    rchk(`AST_OFF_TSC, 32'h22);
    rchk(`AST_OFF_PFLAG, 32'h10);
    $display("test back_to_back done");
    // Frame widths and baud settings; last case sets the ninth bit with nine-bit off
    for (i = 0; i < 4; i++) begin
      apb(1'b1, `AST_OFF_BAUD, bt[i]);
      per = pt[i];
      nine_m = (i < 2);
      apb(1'b1, `AST_OFF_TSC, {25'h0, nine_m, 1'b1, 4'h0, i[0]});
      c = {i == 1, 8'($random(seed))};
      send(c);
      wait_rx(rx_n + 1);
    end
    $display("test formats done");
    // Abort in mid-frame with a character queued
    ign = 1'b1;
    send(9'h055);
    send(9'h0aa);
    repeat (3 * per) @(posedge pclk);
    apb(1'b1, `AST_OFF_RSC, 32'h0);
    repeat (3) @(posedge pclk);
    chk({31'h0, so_pad}, 32'h1);
    apb(1'b1, `AST_OFF_RSC, 32'h80);
    n = 0;
    repeat (2 * per) begin
      @(posedge pclk);
      if (so_pad !== 1'b1) n++;
    end
    chk(n, 32'd0);
    rchk(`AST_OFF_TSC, 32'h23);
    rchk(`AST_OFF_PFLAG, 32'h10);
    // Synchronous mode releases the transmit pin to its direction bit
    apb(1'b1, `AST_OFF_TSC, 32'h30);
    repeat (2) @(posedge pclk);
    chk({31'h0, so_oe}, 32'h0);
    apb(1'b1, `AST_OFF_TSC, 32'h0);
    rchk(`AST_OFF_PFLAG, 32'h0);
    // Port pins as plain outputs; the low pad level comes back through the synchroniser
    apb(1'b1, `AST_OFF_PIN, 32'h8);
    repeat (2) @(posedge pclk);
    chk({29'h0, si_oe, si_out, so_oe}, 32'h7);
    rchk(`AST_OFF_PIN, 32'h28);
    $display("test abort done");
    finish_test();
  end
endmodule : test_ast_tx
